/* testbench/msc_line_model.sv */
// Line transceiver model that echoes the station's transmit line
`timescale 1ns/1ns
`default_nettype none
module msc_line_model (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // Station line outputs
  input  wire logic tx_data_i,
  input  wire logic tx_en_b_i,
  // Echo options
  input  wire logic invert_i,
  input  wire logic pulse_i,
  input  wire logic noise_i,
  // Echo towards the station
  output logic      rx_data_o,
  output logic      carrier_b_o
);
  logic [2:0] ph_q;
  // One cycle echo; released data toggles so a stale level never decodes
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ph_q        <= 3'h0;
      rx_data_o   <= 1'b0;
      carrier_b_o <= 1'b1;
    end else begin
      ph_q <= (ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
      if (!tx_en_b_i) begin
        rx_data_o   <= tx_data_i ^ invert_i;
        carrier_b_o <= pulse_i && ph_q == 3'h5;
      end else begin
        rx_data_o   <= ~rx_data_o;
        carrier_b_o <= ~noise_i;
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/test_manchester_station_codec.sv */
// Self-checking bench for the station Manchester codec
`timescale 1ns/1ns
`default_nettype none
module test_manchester_station_codec;
  import msc_pkg::*;
  localparam int WD = 40; // Short watchdog keeps the run brief
  logic      clk_i = 1'b0;
  logic      rst_b_i = 1'b0;
  msc_mode_s mode = 3'b110;
  logic      tx_d = 1'b0, tx_v = 1'b0, ecol_b = 1'b1;
  logic      inv = 1'b0, pls = 1'b0, nz = 1'b0;
  logic      tx_bit_clock, rxd, rxv, rclk, coll, ld, len_b, ed, ec;
  logic      act = 1'b1, rp = 1'b0;
  int        fail_count = 0, checks_done = 0, cyc = 0, div = 8;
  logic      q[$];
  msc_codec #(.WDOG_BITS(WD)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .mode_i(mode),
    .tx_nrz_data_i(tx_d), .tx_data_valid_i(tx_v), .tx_bit_clock_o(tx_bit_clock), .rx_nrz_data_o(rxd),
    .rx_data_valid_o(rxv), .rx_recovered_clock_o(rclk), .collision_indication_o(coll),
    .line_i({ed, ec, ecol_b}), .line_tx_data_o(ld), .line_tx_output_enable_o(len_b));
  msc_line_model line (.clk_i(clk_i), .rst_b_i(rst_b_i), .tx_data_i(ld), .tx_en_b_i(len_b),
    .invert_i(inv), .pulse_i(pls), .noise_i(nz), .rx_data_o(ed), .carrier_b_o(ec));
  always #5 clk_i = ~clk_i;
  // Receive bits gathered one edge late, when they are settled
  always @(posedge clk_i) begin
    if (rclk !== rp && rclk === mode.style && rxv === act) q.push_back(rxd);
    rp = rclk;
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      $display("unexpected %0t timeout", $time);
      print_verdict();
    end
  end
  task automatic chk1(input logic g, input logic e, input string m);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask
  task automatic chkn(input int g, input int lo, input int hi, input string m);
    checks_done++;
    if (g < lo || g > hi) begin
      fail_count++;
      $display("unexpected %0t %s %0d", $time, m, g);
    end
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Straps change only inside reset; the free-running divider gets 2 * div cycles to settle before its period is checked
  task automatic do_reset(input logic s, input logic lb, input logic d10);
    time t0;
    rst_b_i <= 1'b0;
    mode <= '{s, ~lb, d10};
    tx_v <= ~s;
    nz <= lb;
    act = s;
    div = d10 ? 10 : 8;
    repeat (2 * div) @(posedge clk_i);
    @(posedge tx_bit_clock);
    t0 = $time;
    @(posedge tx_bit_clock);
    chkn(int'(($time - t0) / 10), div, div, "bit clock period");
    chk1(len_b & ~ld, 1'b1, "line in reset");
    chk1(coll, ~s, "collision in reset");
    chk1(rxv, ~s, "receive valid in reset");
    @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (3 * div) @(posedge clk_i);
  endtask
  // One frame: drive bits, decode the line, then look for the payload
  task automatic send(input int n, input logic [31:0] b, input logic lb);
    int t, k;
    logic [15:0] sh;
    q = {};
    fork
      begin
        for (int i = 0; i <= n; i++) begin
          if (mode.style) @(posedge tx_bit_clock);
          else @(negedge tx_bit_clock);
          @(posedge clk_i);
          tx_d <= b[i % 32];
          tx_v <= (i < n) ? act : ~act;
        end
        if (!lb) begin
          for (t = 0; t < 20 * div && coll !== act; t++) @(posedge clk_i);
          chkn(t, 8 * div - 3, 9 * div + 6, "heartbeat delay");
          for (t = 0; t < 30 * div && coll === act; t++) @(posedge clk_i);
          chkn(t, 8 * div - 2, 30 * div, "heartbeat hold");
        end
      end
      begin
        @(posedge clk_i iff tx_v === act);
        if (lb) repeat ((n + 4) * div) begin
          @(posedge clk_i);
          chk1(len_b & ~ld, 1'b1, "line in loopback");
        end else begin
          for (k = 0; len_b !== 1'b0 && k < 6 * div; k++) @(posedge clk_i);
          chkn(k, mode.style ? 0 : 2 * div - 3, mode.style ? 2 * div + 3 : 4 * div + 6, "enable delay");
          for (int i = 0; i < n; i++) begin
            repeat (div / 4) @(posedge clk_i);
            chk1(ld, ~b[i], "first half");
            repeat (div / 2) @(posedge clk_i);
            chk1(ld, b[i], "second half");
            repeat (div - div / 4 - div / 2) @(posedge clk_i);
          end
          for (k = 0; len_b === 1'b0 && k < 4 * div; k++) begin
            chk1(ld, 1'b1, "tail level");
            @(posedge clk_i);
          end
          chkn(k, b[n-1] ? div * 3 / 2 - 2 : 2 * div - 2, b[n-1] ? div * 3 / 2 + 2 : 2 * div + 2, "tail");
        end
      end
    join
    repeat (30 * div) @(posedge clk_i);
    k = 0;
    sh = 16'h0000;
    foreach (q[i]) begin
      sh = {q[i], sh[15:1]};
      if (sh === b[31:16]) k = 1;
    end
    chk1(k[0], 1'b1, "payload decode");
  endtask
  initial begin
    int k;
    void'($urandom(28616));
    for (int c = 0; c < 8; c++) begin
      do_reset(c[0], 1'b0, c[1]);
      inv <= c[2];
      pls <= 1'($urandom);
      send(32, {(c < 2) ? {c[0], 15'h0000} : 16'($urandom), 16'haaaa}, 1'b0);
    end
    do_reset(1'b1, 1'b1, 1'b1);
    send(32, {16'($urandom), 16'haaaa}, 1'b1);
    // External collision, held low until seen, in both styles
    for (int s = 0; s < 2; s++) begin
      do_reset(s[0], 1'b0, 1'b0);
      @(posedge clk_i);
      ecol_b <= 1'b0;
      for (k = 0; coll !== act && k < 10; k++) @(posedge clk_i);
      ecol_b <= 1'b1;
      chkn(k, 1, 8, "external collision");
    end
    // Endless transmission cut by the watchdog
    do_reset(1'b1, 1'b0, 1'b0);
    @(posedge clk_i);
    tx_v <= act;
    for (k = 0; len_b !== 1'b0 && k < 5 * div; k++) @(posedge clk_i);
    for (k = 0; len_b === 1'b0 && k < (WD + 8) * div; k++) begin
      @(posedge clk_i);
      tx_d <= 1'($urandom);
    end
    chkn(k, (WD - 3) * div, (WD + 1) * div, "watchdog cut");
    chk1(coll, act, "watchdog collision");
    tx_v <= ~act;
    repeat (10 * div) @(posedge clk_i);
    print_verdict();
  end
endmodule
`default_nettype wire

/* verilog/msc_cfg.svh */
// Timing and field constants for the station Manchester codec
`ifndef MSC_CFG_SVH
`define MSC_CFG_SVH
`define MSC_DIV8           4'h8
`define MSC_DIV10          4'ha
`define MSC_CLK_PERIOD_NS  10
`define MSC_ECOL_MIN_NS    20
`define MSC_ECOL_CYC       ((`MSC_ECOL_MIN_NS + `MSC_CLK_PERIOD_NS - 1) / `MSC_CLK_PERIOD_NS)
`define MSC_CAR_SAMPLES    2'h3
`define MSC_CAR_HOLD_BITS  8'h02
`define MSC_TX_DELAY_BITS  3'h2
`define MSC_HB_DELAY_BITS  4'h8
`define MSC_HB_HOLD_BITS   4'h8
`define MSC_WDOG_BITS      32'd101000
`define MSC_WDOG_LB_BITS   32'd325
`define MSC_ECHO_BITS      16'd510
`define MSC_PROT_BITS      8'h14
`define MSC_LOCK_LONGS     2'h2
`endif

/* verilog/msc_codec.sv */
// Station Manchester encoder/decoder with squelch, polarity fix and collision logic
// Function
// - Style 0: sample transmit NRZ data on rising bit clock edge.
// - Style 0: receive NRZ data changes on rising recovered clock edge.
// - Style 0: valid and collision signals active low; receive valid needs lock.
// - Style 1: valid and collision signals active high; receive valid needs lock.
// - Loopback low: transmit loops to receive, line data and carrier ignored (external collision still honoured), line outputs inactive.
// - In reset all outputs inhibited except the transmit bit clock.
// - Oscillator divided by 8 or by 10 per divider select.
// - External collision low at least 20 ns signals collision.
// - Collision on Manchester violation or external collision.
// - Style 0: encoding starts two bit times after transmit valid.
// - Output enable goes low with first encoded bit.
// - Style 1: transmit valid to output enable under two bit clocks.
// - After data, line high 1.5 bits after one, 2 after zero.
// - Output enable goes high at end of transmission.
// - Decode only with valid carrier; NRZ out with recovered clock.
// - Carrier accepted as level or pulse stream, made a level.
// - Carrier valid after three consecutive active samples.
// - Carrier stays valid with one active sample per two bit times.
// - Inverted polarity frame detected and decoded correctly.
// - Counter restarts on transitions; lock after two long transitions.
// - Watchdog: 101K bits (325 loopback) gives collision, disables enable.
// - Echo timer: no receive valid within 510 bits gives collision.
// - Heartbeat 8 bits after transmit ends, held 8; others until idle.
`timescale 1ns/1ns
`default_nettype none
`include "msc_cfg.svh"
module msc_codec #(
  parameter int unsigned WDOG_BITS = `MSC_WDOG_BITS
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_b_i,
  // Mode straps
  input  wire msc_pkg::msc_mode_s mode_i,
  // Controller side
  input  wire logic          tx_nrz_data_i,
  input  wire logic          tx_data_valid_i,
  output logic               tx_bit_clock_o,
  output logic               rx_nrz_data_o,
  output logic               rx_data_valid_o,
  output logic               rx_recovered_clock_o,
  output logic               collision_indication_o,
  // Line side
  input  wire msc_pkg::msc_line_s line_i,
  output logic               line_tx_data_o,
  output logic               line_tx_output_enable_o
);
  import msc_pkg::*;

  // Two-stage synchronisers; no reset, since a fixed reset level would fake transmit valid in one style
  logic [4:0] s1_q, s2_q;
  always_ff @(posedge clk_i) begin
    s1_q <= {tx_nrz_data_i, tx_data_valid_i, line_i.data, line_i.carrier_n, line_i.ecol_n};
    s2_q <= s1_q;
  end
  wire logic sty = mode_i.style;
  wire logic txd = s2_q[4];
  wire logic tven = sty ? s2_q[3] : ~s2_q[3];
  wire logic loop = ~mode_i.loop_n;

  // Oscillator divider; bit clock keeps running through reset
  logic [3:0] div_q = 4'h0; // Power-up value: reset must not stop the divider
  wire logic [3:0] divn = mode_i.div10 ? `MSC_DIV10 : `MSC_DIV8;
  wire logic bit_tick = (div_q == divn - 4'h1);
  wire logic half_tick = (div_q == (divn >> 1) - 4'h1);
  always_ff @(posedge clk_i) begin
    div_q <= bit_tick ? 4'h0 : div_q + 4'h1;
    tx_bit_clock_o <= (div_q < (divn >> 1));
  end
  // Rising bit-clock edge point is bit_tick; falling at half_tick
  wire logic samp = sty ? half_tick : bit_tick;

  // Style 0 starts encoding two bits late; data and valid ride a short pipe so no bit is lost
  logic [`MSC_TX_DELAY_BITS-1:0] dpipe_q, vpipe_q;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dpipe_q <= '0;
      vpipe_q <= '0;
    end else if (samp) begin
      dpipe_q <= {dpipe_q[0], txd};
      vpipe_q <= {vpipe_q[0], tven};
    end
  end
  wire logic td_use = sty ? txd : dpipe_q[`MSC_TX_DELAY_BITS-1];
  wire logic tv_use = sty ? tven : vpipe_q[`MSC_TX_DELAY_BITS-1];

  // Transmit sequencer
  msc_tx_e st_q;
  logic [2:0] dly_q;
  logic cur_q, tail_half_q;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= MSC_TX_IDLE;
      dly_q <= 3'h0;
      cur_q <= 1'b0;
      tail_half_q <= 1'b0;
    end else if (samp) begin
      case (st_q)
        MSC_TX_IDLE: begin
          if (tv_use) begin
            cur_q <= td_use;
            st_q <= MSC_TX_DATA;
          end
        end
        MSC_TX_DATA: begin
          cur_q <= td_use;
          if (!tv_use) begin
            st_q <= MSC_TX_TAIL;
            dly_q <= 3'h0;
            tail_half_q <= cur_q; // last bit one: 1.5 bits
          end
        end
        MSC_TX_TAIL: begin
          dly_q <= dly_q + 3'h1;
          if (dly_q == 3'h1) st_q <= MSC_TX_IDLE;
        end
        default: st_q <= MSC_TX_IDLE;
      endcase
    end
  end
  // Phase within bit: first half carries complement, second half value
  // Halves counted from the sample point, so the bit cell follows the state change
  wire logic second_half = sty ? (div_q < (divn >> 1)) : (div_q >= (divn >> 1));
  wire logic enc = (st_q == MSC_TX_TAIL) ? 1'b1 : (second_half ? cur_q : ~cur_q);
  wire logic tx_act = (st_q == MSC_TX_DATA) || (st_q == MSC_TX_TAIL && !(tail_half_q && dly_q == 3'h1 && second_half));

  // Watchdog and echo timers, counted in bits
  logic [31:0] wd_q;
  logic [15:0] echo_q;
  logic wd_exp_q, echo_exp_q;
  wire logic [31:0] wd_lim = loop ? `MSC_WDOG_LB_BITS : WDOG_BITS;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wd_q <= 32'h0;
      wd_exp_q <= 1'b0;
    end else if (!tven) begin
      wd_q <= 32'h0;
      wd_exp_q <= 1'b0;
    end else if (bit_tick && !wd_exp_q) begin
      wd_q <= wd_q + 32'h1;
      wd_exp_q <= (wd_q + 32'h1 >= wd_lim);
    end
  end
  logic rval_q;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      echo_q <= 16'h0;
      echo_exp_q <= 1'b0;
    end else if (!tven) begin
      echo_q <= 16'h0;
      echo_exp_q <= 1'b0;
    end else if (bit_tick && !rval_q && !echo_exp_q) begin
      echo_q <= echo_q + 16'h1;
      echo_exp_q <= (echo_q + 16'h1 >= `MSC_ECHO_BITS);
    end
  end

  // Line outputs, forced inactive in loopback or after watchdog
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      line_tx_data_o <= 1'b0;
      line_tx_output_enable_o <= 1'b1;
    end else begin
      line_tx_data_o <= (tx_act && !loop && !wd_exp_q) ? enc : 1'b0;
      line_tx_output_enable_o <= ~(tx_act && !loop && !wd_exp_q);
    end
  end

  // Receive source select and carrier squelch
  wire logic rxd = loop ? enc : s2_q[2];
  wire logic car = loop ? tx_act : ~s2_q[1];
  logic [1:0] car_run_q;
  logic [7:0] car_gap_q;
  logic car_ok_q;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      car_run_q <= 2'h0;
      car_gap_q <= 8'h0;
      car_ok_q <= 1'b0;
    end else begin
      car_run_q <= car ? ((car_run_q == `MSC_CAR_SAMPLES) ? car_run_q : car_run_q + 2'h1) : 2'h0;
      if (car) car_gap_q <= 8'h0;
      else if (bit_tick) car_gap_q <= car_gap_q + 8'h1;
      if (!car_ok_q && car && car_run_q == `MSC_CAR_SAMPLES - 2'h1) car_ok_q <= 1'b1;
      else if (car_ok_q && !car && bit_tick && car_gap_q + 8'h1 >= `MSC_CAR_HOLD_BITS) car_ok_q <= 1'b0;
    end
  end

  // DPLL: counter cleared on each transition, long transitions give lock
  logic rxd_q, pol_q, lock_seen_q, first_q;
  logic [4:0] ph_q;
  logic [1:0] longs_q;
  logic [7:0] prot_q;
  wire logic edge_rx = rxd ^ rxd_q;
  wire logic [4:0] long_lim = mode_i.div10 ? 5'h7 : 5'h5;
  wire logic [4:0] viol_lim = mode_i.div10 ? 5'h0c : 5'h0a;
  wire logic is_long = (ph_q >= long_lim);
  wire logic locked = (longs_q == `MSC_LOCK_LONGS);
  // A late edge under live carrier is a missing mid-bit; end of frame has no edge, so no false hit
  wire logic viol = car && car_ok_q && locked && edge_rx && (ph_q >= viol_lim);
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rxd_q <= 1'b0;
      ph_q <= 5'h0;
      longs_q <= 2'h0;
      pol_q <= 1'b0;
      first_q <= 1'b1;
      lock_seen_q <= 1'b0;
    end else begin
      rxd_q <= rxd;
      if (!car_ok_q) begin
        ph_q <= 5'h0;
        longs_q <= 2'h0;
        first_q <= 1'b1;
      end else if (edge_rx) begin
        ph_q <= 5'h0;
        if (is_long && !locked) begin
          longs_q <= longs_q + 2'h1;
          if (first_q) pol_q <= rxd_q; // Preamble long run sets frame polarity
          first_q <= 1'b0;
        end
      end else if (ph_q != 5'h1f) begin
        ph_q <= ph_q + 5'h1;
      end
      lock_seen_q <= locked;
    end
  end

  // Decoder: value after mid-bit edge, polarity corrected; long edges are always mid-bit
  logic [3:0] rclk_cnt_q;
  logic exp_mid_q;
  wire logic mid_edge = is_long || exp_mid_q;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_nrz_data_o <= 1'b0;
      rclk_cnt_q <= 4'h0;
      rx_recovered_clock_o <= 1'b0;
      rval_q <= 1'b0;
      prot_q <= 8'h0;
      exp_mid_q <= 1'b0;
    end else begin
      if (!car_ok_q) exp_mid_q <= 1'b0;
      else if (edge_rx) exp_mid_q <= !mid_edge;
      if (car_ok_q && edge_rx && mid_edge) begin
        rclk_cnt_q <= 4'h0;
        rx_nrz_data_o <= rxd ^ pol_q;
      end else begin
        rclk_cnt_q <= (rclk_cnt_q == divn - 4'h1) ? 4'h0 : rclk_cnt_q + 4'h1;
      end
      // Style 0 clock rises as data changes, style 1 falls then
      rx_recovered_clock_o <= locked && car_ok_q && ((rclk_cnt_q >= (divn >> 1)) == sty);
      if (rval_q && !car_ok_q) prot_q <= `MSC_PROT_BITS;
      else if (bit_tick && prot_q != 8'h0) prot_q <= prot_q - 8'h1;
      rval_q <= car_ok_q && locked && (prot_q == 8'h0);
    end
  end
  assign rx_data_valid_o = sty ? rval_q : ~rval_q;

  // External collision filter and collision latch
  logic [1:0] ecol_cnt_q;
  logic col_q, hb_q, tven_q, car_seen_q;
  logic [3:0] hb_cnt_q;
  wire logic ecol = (ecol_cnt_q >= 2'(`MSC_ECOL_CYC));
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) ecol_cnt_q <= 2'h0;
    else if (s2_q[0]) ecol_cnt_q <= 2'h0;
    else if (!ecol) ecol_cnt_q <= ecol_cnt_q + 2'h1;
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      col_q <= 1'b0;
      car_seen_q <= 1'b0;
      tven_q <= 1'b0;
    end else begin
      tven_q <= tven;
      car_seen_q <= tven ? (car_seen_q | car_ok_q) : 1'b0;
      if (ecol || viol || wd_exp_q || echo_exp_q || (tven && car_seen_q && !car_ok_q)) col_q <= 1'b1;
      else if (!tven && !rval_q) col_q <= 1'b0;
    end
  end
  // Heartbeat: wait 8 bits after transmit end, then hold 8 bits
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hb_q <= 1'b0;
      hb_cnt_q <= 4'h0;
    end else if (tven_q && !tven) begin
      hb_cnt_q <= 4'h1;
      hb_q <= 1'b0;
    end else if (bit_tick && hb_cnt_q != 4'h0) begin
      if (!hb_q && hb_cnt_q == `MSC_HB_DELAY_BITS) begin
        hb_q <= 1'b1;
        hb_cnt_q <= 4'h1;
      end else if (hb_q && hb_cnt_q == `MSC_HB_HOLD_BITS) begin
        hb_q <= 1'b0;
        hb_cnt_q <= 4'h0;
      end else hb_cnt_q <= hb_cnt_q + 4'h1;
    end
  end
  assign collision_indication_o = sty ? (col_q | hb_q) : ~(col_q | hb_q);

  // Checks
  AST_LOOP_QUIET: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    loop |=> line_tx_output_enable_o) else $error("line enable active in loopback");
  AST_RVAL_LOCK: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rval_q |-> $past(locked)) else $error("receive valid without lock");
  AST_ECOL: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!s2_q[0])[*3] |=> col_q) else $error("external collision missed");
  AST_WDOG: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wd_exp_q |=> line_tx_output_enable_o) else $error("watchdog left enable on");
  AST_CAR_VALID: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(car_ok_q) |-> $past(car, 1) && $past(car, 2) && $past(car, 3)) else $error("carrier too early");
  AST_COL_HOLD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    col_q && (tven || rval_q) |=> col_q) else $error("collision dropped while busy");
  AST_TAIL_HIGH: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    st_q == MSC_TX_TAIL && tx_act && !loop && !wd_exp_q |=> line_tx_data_o) else $error("tail not high");
  AST_IDLE_OFF: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    st_q == MSC_TX_IDLE |=> line_tx_output_enable_o) else $error("enable active when idle");
  COV_TX: cover property (@(posedge clk_i) disable iff (!rst_b_i) st_q == MSC_TX_TAIL);
  COV_LOCK: cover property (@(posedge clk_i) disable iff (!rst_b_i) $rose(rval_q));
  COV_HB: cover property (@(posedge clk_i) disable iff (!rst_b_i) $rose(hb_q));
endmodule
`default_nettype wire

/* verilog/msc_pkg.sv */
// Types for the station Manchester codec
package msc_pkg;
  typedef enum logic [2:0] {
    MSC_TX_IDLE  = 3'b000,
    MSC_TX_DELAY = 3'b001,
    MSC_TX_DATA  = 3'b010,
    MSC_TX_TAIL  = 3'b011
  } msc_tx_e;
  typedef struct packed {
    logic style;
    logic loop_n;
    logic div10;
  } msc_mode_s;
  typedef struct packed {
    logic data;
    logic carrier_n;
    logic ecol_n;
  } msc_line_s;
endpackage
